// ===== rtl/rcf_front_end.sv
// Command splitter, classifier and response terminator for two host ports.
// Assumes byte streams come from GPIB and serial controllers on the same clock.
// Functional notes
// (R1) Command starting with asterisk is a common command.
// (R2) Command not starting with asterisk is device dependent.
// (R3) Command ending with question mark is a query needing a response.
// (R4) A response-invoking command is a query; its response is queued.
// (R5) Split transmissions at semicolons and execute parts in order.
// (R6) Serial port ends a command on CR or LF.
// (R7) GPIB port ends a command on EOI byte, newline or CR.
// (R8) Carriage return is byte 0x0d.
// (R9) Line feed and newline are byte 0x0a.
// (R10) End of message is EOI together with a newline byte.
// (R11) Host should end GPIB commands with EOI plus newline.
// (R12) Individual status derives from status byte and poll enable mask.
// (R13) Numbers travel as ASCII strings, never binary.
// (R14) Host reads complete response before next command.
// (R15) Host serial-polls message available before reading GPIB response.
// (R16) Serial port uses the same syntax as GPIB.
// (R17) Serial responses end CR LF with echo, single newline otherwise.
// (R18) GPIB responses end with EOI on a newline byte.
// (R19) Any command switches to remote mode and records the port.
// (R20) Message available set while response waits, cleared when drained.
// (R21) Empty segments are discarded silently.
module rcf_front_end (
    input  wire logic               clock,
    input  wire logic               reset_n,
    input  wire rcf_pkg::rcf_rx_t   rx,
    input  wire logic               rx_valid,
    output logic                    rx_ready,
    output rcf_pkg::rcf_cmd_t       cmd,
    output logic                    cmd_valid,
    input  wire logic               cmd_ready,
    input  wire logic [7:0]         resp_data,
    input  wire logic               resp_valid,
    input  wire logic               resp_last,
    output logic                    resp_ready,
    output rcf_pkg::rcf_tx_t        tx,
    output logic                    tx_valid,
    input  wire logic               tx_ready,
    input  wire logic               echo_enable,
    input  wire logic [7:0]         status_byte,
    input  wire logic [7:0]         poll_enable,
    input  wire logic               local_request,
    output logic [7:0]              status_out,
    output logic                    individual_status_flag,
    output logic                    message_available_flag,
    output logic                    remote_mode,
    output rcf_pkg::rcf_port_t      remote_port
);
    // Assembly of the current segment
    logic [rcf_pkg::MAX_LEN*8-1:0] text_q;
    logic [rcf_pkg::LEN_W-1:0]     len_q;
    logic                          last_qm_q;
    rcf_pkg::rcf_port_t            port_q;

    // Two-entry buffer of finished commands
    rcf_pkg::rcf_cmd_t buf_q [rcf_pkg::BUF_DEPTH];
    logic              wr_q;
    logic              rd_q;
    logic [1:0]        cnt_q;

    // Response store and output terminator state
    logic [7:0]               rmem [rcf_pkg::RESP_DEPTH];
    logic [rcf_pkg::RESP_AW-1:0] rwp_q;
    logic [rcf_pkg::RESP_AW-1:0] rrp_q;
    logic [rcf_pkg::RESP_AW:0]   rcnt_q;
    logic                     resp_done_q;
    rcf_pkg::rcf_port_t       resp_port_q;
    logic                     pend_q;

    typedef enum logic [3:0] {
        RCF_TX_IDLE = 4'b0001,
        RCF_TX_BODY = 4'b0010,
        RCF_TX_CR   = 4'b0100,
        RCF_TX_NL   = 4'b1000
    } rcf_tx_state_t;
    rcf_tx_state_t txs_q;

    // Terminator test per port
    function automatic logic is_term(input rcf_pkg::rcf_rx_t b);
        logic eol;
        eol = (b.data == rcf_pkg::CR_BYTE) || (b.data == rcf_pkg::LF_BYTE); // [R8] [R9]
        if (b.port == rcf_pkg::RCF_PORT_GPIB)
            is_term = eol || b.eoi; // [R7] [R10]
        else
            is_term = eol; // [R6] [R16]
    endfunction : is_term

    // Receive decode
    wire logic buf_full  = (cnt_q == 2'd2);
    wire logic rx_term   = is_term(rx);
    wire logic rx_semi   = (rx.data == rcf_pkg::SEMI_BYTE); // [R5]
    wire logic rx_end    = rx_term || rx_semi;
    // A GPIB byte with EOI that is not itself a delimiter is part of the command
    wire logic rx_keep   = !(rx.data == rcf_pkg::CR_BYTE || rx.data == rcf_pkg::LF_BYTE || rx_semi);
    wire logic rx_take   = rx_valid && rx_ready;
    wire logic [rcf_pkg::LEN_W-1:0] fin_len =
        (rx_keep && len_q < rcf_pkg::LEN_W'(rcf_pkg::MAX_LEN)) ? len_q + 1'b1 : len_q;
    wire logic [rcf_pkg::MAX_LEN*8-1:0] fin_text =
        (rx_keep && len_q < rcf_pkg::LEN_W'(rcf_pkg::MAX_LEN)) ?
        (text_q | ({{(rcf_pkg::MAX_LEN*8-8){1'b0}}, rx.data} << (len_q * 8))) : text_q;
    wire logic fin_qm    = rx_keep ? (rx.data == rcf_pkg::QM_BYTE) : last_qm_q;
    wire logic push      = rx_take && rx_end && (fin_len != '0); // [R21]
    wire logic cmd_pop   = cmd_valid && cmd_ready;

    // Stall all input whenever the command buffer holds two finished commands
    assign rx_ready  = !buf_full;
    assign cmd_valid = (cnt_q != 2'd0);
    assign cmd       = buf_q[rd_q];

    // Classified entry built at the delimiter
    rcf_pkg::rcf_cmd_t new_cmd;
    assign new_cmd.text   = fin_text;
    assign new_cmd.len    = fin_len;
    assign new_cmd.common = (fin_text[7:0] == rcf_pkg::STAR_BYTE); // [R1] [R2]
    assign new_cmd.query  = fin_qm; // [R3] [R4]
    assign new_cmd.port   = rx.port;

    // Segment assembly; delimiters clear it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            text_q    <= '0;
            len_q     <= '0;
            last_qm_q <= 1'b0;
        end else if (rx_take) begin
            text_q    <= rx_end ? '0 : fin_text; // [R5]
            len_q     <= rx_end ? '0 : fin_len;
            last_qm_q <= rx_end ? 1'b0 : fin_qm;
        end
    end

    // Command buffer, in order of arrival
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                buf_q[wr_q] <= new_cmd; // [R5]
                wr_q        <= ~wr_q;
            end
            if (cmd_pop)
                rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, cmd_pop};
        end
    end

    // Remote mode and last port; a new command beats a local request
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            remote_mode <= 1'b0;
            remote_port <= rcf_pkg::RCF_PORT_NONE;
            port_q      <= rcf_pkg::RCF_PORT_NONE;
        end else if (push) begin
            remote_mode <= 1'b1; // [R19]
            remote_port <= rx.port;
            port_q      <= rx.port;
        end else if (local_request) begin
            remote_mode <= 1'b0;
        end
    end

    // Response queue; the executor supplies ASCII text only
    wire logic rfull  = (rcnt_q == (rcf_pkg::RESP_AW+1)'(rcf_pkg::RESP_DEPTH));
    wire logic rempty = (rcnt_q == '0);
    wire logic rpush  = resp_valid && resp_ready; // [R13]
    wire logic rpop   = (txs_q == RCF_TX_BODY) && tx_ready && !rempty;
    assign resp_ready = !rfull && !resp_done_q;

    always_ff @(posedge clock) begin
        if (rpush)
            rmem[rwp_q] <= resp_data; // [R4]
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rwp_q  <= '0;
            rrp_q  <= '0;
            rcnt_q <= '0;
        end else begin
            if (rpush)
                rwp_q <= rwp_q + 1'b1;
            if (rpop)
                rrp_q <= rrp_q + 1'b1;
            rcnt_q <= rcnt_q + {{rcf_pkg::RESP_AW{1'b0}}, rpush} - {{rcf_pkg::RESP_AW{1'b0}}, rpop};
        end
    end

    // Response completeness and pending flag
    wire logic tx_fin = (txs_q == RCF_TX_NL) && tx_ready;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            resp_done_q <= 1'b0;
            resp_port_q <= rcf_pkg::RCF_PORT_NONE;
            pend_q      <= 1'b0;
        end else begin
            if (rpush && resp_last) begin
                resp_done_q <= 1'b1;
                resp_port_q <= port_q;
            end else if (tx_fin) begin
                resp_done_q <= 1'b0;
            end
            // Set wins over clear
            if (rpush)
                pend_q <= 1'b1; // [R20]
            else if (tx_fin)
                pend_q <= 1'b0; // [R20]
        end
    end

    // Output sequencer: body, then terminator for the port
    wire logic [7:0] body_byte = rmem[rrp_q];
    wire logic       ser_echo  = (resp_port_q == rcf_pkg::RCF_PORT_SERIAL) && echo_enable;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            txs_q <= RCF_TX_IDLE;
        end else begin
            unique case (txs_q)
                RCF_TX_IDLE: begin
                    if (resp_done_q)
                        txs_q <= RCF_TX_BODY;
                end
                RCF_TX_BODY: begin
                    if (rempty)
                        txs_q <= ser_echo ? RCF_TX_CR : RCF_TX_NL; // [R17]
                end
                RCF_TX_CR: begin
                    if (tx_ready)
                        txs_q <= RCF_TX_NL;
                end
                RCF_TX_NL: begin
                    if (tx_ready)
                        txs_q <= RCF_TX_IDLE;
                end
                default: txs_q <= RCF_TX_IDLE;
            endcase
        end
    end

    // Outgoing byte selection
    assign tx_valid     = ((txs_q == RCF_TX_BODY) && !rempty) || (txs_q == RCF_TX_CR) || (txs_q == RCF_TX_NL);
    assign tx.port      = resp_port_q;
    assign tx.data      = (txs_q == RCF_TX_CR) ? rcf_pkg::CR_BYTE :
                          (txs_q == RCF_TX_NL) ? rcf_pkg::LF_BYTE : body_byte; // [R17]
    assign tx.eoi       = (txs_q == RCF_TX_NL) && (resp_port_q == rcf_pkg::RCF_PORT_GPIB); // [R18]

    // Status byte and parallel poll bit
    logic [7:0] stb_q;
    logic       indiv_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stb_q   <= '0;
            indiv_q <= 1'b0;
        end else begin
            stb_q   <= {status_byte[7:rcf_pkg::AVAIL_BIT+1], pend_q, status_byte[rcf_pkg::AVAIL_BIT-1:0]};
            indiv_q <= |({status_byte[7:rcf_pkg::AVAIL_BIT+1], pend_q,
                          status_byte[rcf_pkg::AVAIL_BIT-1:0]} & poll_enable); // [R12]
        end
    end
    assign status_out             = stb_q;
    assign message_available_flag = pend_q;
    assign individual_status_flag = indiv_q;

    // Checks
    a_empty_dropped: assert property (@(posedge clock) disable iff (!reset_n)
        rx_take && rx_end && len_q == '0 && !rx_keep |=> cnt_q == $past(cnt_q) - {1'b0, $past(cmd_pop)})
        else $error("empty segment stored"); // [R21]
    a_star_common: assert property (@(posedge clock) disable iff (!reset_n)
        push && !cmd_pop && cnt_q == 2'd0 |=> cmd.common == ($past(fin_text[7:0]) == 8'h2a))
        else $error("common class wrong"); // [R1]
    a_query_class: assert property (@(posedge clock) disable iff (!reset_n)
        push && cnt_q == 2'd0 |=> cmd.query == $past(fin_qm))
        else $error("query class wrong"); // [R3]
    a_serial_term: assert property (@(posedge clock) disable iff (!reset_n)
        rx_valid && rx.port == rcf_pkg::RCF_PORT_SERIAL && (rx.data == 8'h0d || rx.data == 8'h0a) |-> rx_end)
        else $error("serial terminator missed"); // [R6]
    a_gpib_eoi: assert property (@(posedge clock) disable iff (!reset_n)
        rx_valid && rx.port == rcf_pkg::RCF_PORT_GPIB && rx.eoi |-> rx_end)
        else $error("gpib eoi missed"); // [R7]
    a_remote_set: assert property (@(posedge clock) disable iff (!reset_n)
        push |=> remote_mode && remote_port == $past(rx.port))
        else $error("remote mode not set"); // [R19]
    a_gpib_end: assert property (@(posedge clock) disable iff (!reset_n)
        tx_valid && tx.eoi |-> tx.data == 8'h0a && tx.port == rcf_pkg::RCF_PORT_GPIB)
        else $error("eoi without newline"); // [R18]
    sequence s_cr_sent;
        tx_valid && tx_ready && tx.data == 8'h0d && txs_q == RCF_TX_CR;
    endsequence
    a_crlf_order: assert property (@(posedge clock) disable iff (!reset_n)
        s_cr_sent |=> tx_valid && tx.data == 8'h0a)
        else $error("cr not followed by lf"); // [R17]
    a_mav_flag: assert property (@(posedge clock) disable iff (!reset_n)
        rpush |=> message_available_flag ##1 status_out[4])
        else $error("message available not set"); // [R20]
    a_ist_calc: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(individual_status_flag) |-> $past(|(poll_enable & {status_byte[7:5], pend_q, status_byte[3:0]})))
        else $error("individual status wrong"); // [R12]
endmodule : rcf_front_end

// ===== rtl/rcf_pkg.sv
// Shared constants and carrier types for the remote command front end.
// Assumes one 200 MHz clock and byte-wide ports from the port controllers.
package rcf_pkg;
    localparam logic [7:0] CR_BYTE   = 8'h0d;
    localparam logic [7:0] LF_BYTE   = 8'h0a;
    localparam logic [7:0] STAR_BYTE = 8'h2a;
    localparam logic [7:0] QM_BYTE   = 8'h3f;
    localparam logic [7:0] SEMI_BYTE = 8'h3b;
    localparam int         MAX_LEN   = 32;
    localparam int         LEN_W     = 6;
    localparam int         RESP_DEPTH = 64;
    localparam int         RESP_AW   = 6;
    localparam int         AVAIL_BIT = 4;
    localparam int         RQS_BIT   = 6;
    localparam int         BUF_DEPTH = 2;

    // Port that delivered the byte or command
    typedef enum logic [1:0] {
        RCF_PORT_NONE   = 2'b00,
        RCF_PORT_GPIB   = 2'b01,
        RCF_PORT_SERIAL = 2'b10
    } rcf_port_t;

    // Byte received from a port controller
    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
        rcf_port_t  port;
    } rcf_rx_t;

    // Completed command segment handed to the executor
    typedef struct packed {
        logic [MAX_LEN*8-1:0] text;
        logic [LEN_W-1:0]     len;
        logic                 common;
        logic                 query;
        rcf_port_t            port;
    } rcf_cmd_t;

    // Byte sent back to a host
    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
        rcf_port_t  port;
    } rcf_tx_t;
endpackage : rcf_pkg

// ===== tb/rcf_host_model.sv
// Host computer model: sends command bytes and reads response bytes.
// Assumes the bench calls send from just after a rising clock edge.
module rcf_host_model (
    input  wire logic              clock,
    input  wire logic              rx_ready,
    input  wire rcf_pkg::rcf_tx_t  tx,
    input  wire logic              tx_valid,
    input  wire logic              stall,
    input  wire logic              msg_avail,
    output rcf_pkg::rcf_rx_t       rx,
    output logic                   rx_valid,
    output logic                   tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    rcf_pkg::rcf_tx_t got_q[$];

    // Idle bus at start
    initial begin
        rx = '0;
        rx_valid = 1'b0;
    end

    // Reads GPIB data only once a reply is flagged as waiting
    assign tx_ready = !stall && (msg_avail || tx.port != rcf_pkg::RCF_PORT_GPIB);

    // Collect every byte taken at the next edge; sampled mid-cycle, where outputs are settled
    always @(negedge clock) begin
        if (tx_valid && tx_ready)
            got_q.push_back(tx);
    end

    // One byte, held until taken at a rising edge
    task automatic send(input logic [7:0] d, input logic e, input rcf_pkg::rcf_port_t p);
        logic ok;
        rx <= '{data: d, eoi: e, port: p};
        rx_valid <= 1'b1;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clock);
            ok = rx_ready;
            @(posedge clock);
        end
        #1;
    endtask : send

    // Released bus shows no stale byte
    task automatic release_bus();
        rx_valid <= 1'b0;
        rx.data <= ~rx.data;
    endtask : release_bus
endmodule : rcf_host_model

// ===== tb/tb_top.sv
// Bench for the command front end, with a queue model of split commands.
// Assumes rcf_host_model as far side; executor side is driven here.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, rx_valid, rx_ready, cmd_valid, cmd_ready, resp_valid, resp_last, resp_ready;
    logic tx_valid, tx_ready, echo_enable, local_request, indiv_stat, msg_avail, remote_mode, stall, hold;
    logic [7:0] resp_data, status_byte, poll_enable, status_out, exp_sb;
    logic [7:0] cur[$];
    logic [255:0] m;
    rcf_pkg::rcf_rx_t rx;
    rcf_pkg::rcf_cmd_t cmd, exp_c;
    rcf_pkg::rcf_cmd_t exp_q[$];
    rcf_pkg::rcf_tx_t tx;
    rcf_pkg::rcf_tx_t tx_q[$];
    rcf_pkg::rcf_port_t remote_port, last_port;
    int fails, samples_checked;
    string s;

    rcf_front_end uut (.clock(clock), .reset_n(reset_n), .rx(rx), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .resp_data(resp_data),
        .resp_valid(resp_valid), .resp_last(resp_last), .resp_ready(resp_ready), .tx(tx),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .echo_enable(echo_enable), .status_byte(status_byte),
        .poll_enable(poll_enable), .local_request(local_request), .status_out(status_out),
        .individual_status_flag(indiv_stat), .message_available_flag(msg_avail), .remote_mode(remote_mode),
        .remote_port(remote_port));
    rcf_host_model host (.clock(clock), .rx_ready(rx_ready), .tx(tx), .tx_valid(tx_valid), .stall(stall),
        .msg_avail(msg_avail), .rx(rx), .rx_valid(rx_valid), .tx_ready(tx_ready));

    // Clock and watchdog
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // Reference splitter: one byte at a time
    task automatic model_byte(input logic [7:0] b, input logic e, input rcf_pkg::rcf_port_t p);
        logic t, fin;
        t = b == rcf_pkg::CR_BYTE || b == rcf_pkg::LF_BYTE || b == rcf_pkg::SEMI_BYTE;
        fin = t || (e && p == rcf_pkg::RCF_PORT_GPIB);
        if (!t && cur.size() < rcf_pkg::MAX_LEN)
            cur.push_back(b);
        if (fin && cur.size() > 0) begin
            exp_c = '0;
            foreach (cur[i]) exp_c.text[8*i +: 8] = cur[i];
            exp_c.len = 6'(cur.size());
            exp_c.common = cur[0] == rcf_pkg::STAR_BYTE;
            exp_c.query = cur[cur.size()-1] == rcf_pkg::QM_BYTE;
            exp_c.port = p;
            exp_q.push_back(exp_c);
            last_port = p;
        end
        if (fin)
            cur.delete();
    endtask : model_byte

    task automatic send_str(input string str, input rcf_pkg::rcf_port_t p, input logic eoi_last);
        foreach (str[i]) begin
            host.send(str[i], eoi_last && i == str.len() - 1, p);
            model_byte(str[i], eoi_last && i == str.len() - 1, p);
        end
        host.release_bus();
    endtask : send_str

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 500) begin
            @(posedge clock);
            n++;
        end
        #1;
        check(exp_q.size() == 0, "commands missing");
    endtask : drain

    // Stall the host, queue a reply, then read it out and compare
    task automatic respond(input string str);
        logic ok;
        int n;
        stall = 1'b1;
        foreach (str[i]) begin
            resp_data <= str[i];
            resp_valid <= 1'b1;
            resp_last <= i == str.len() - 1;
            ok = 1'b0;
            while (!ok) begin
                @(negedge clock);
                ok = resp_ready;
                @(posedge clock);
            end
            #1;
            tx_q.push_back('{data: str[i], eoi: 1'b0, port: last_port});
        end
        resp_valid <= 1'b0;
        resp_data <= ~resp_data;
        if (last_port == rcf_pkg::RCF_PORT_GPIB)
            tx_q.push_back('{data: rcf_pkg::LF_BYTE, eoi: 1'b1, port: last_port});
        else begin
            if (echo_enable)
                tx_q.push_back('{data: rcf_pkg::CR_BYTE, eoi: 1'b0, port: last_port});
            tx_q.push_back('{data: rcf_pkg::LF_BYTE, eoi: 1'b0, port: last_port});
        end
        repeat (2) @(posedge clock);
        #1;
        check(msg_avail === 1'b1 && status_out[rcf_pkg::AVAIL_BIT] === 1'b1, "reply not flagged");
        stall = 1'b0;
        n = 0;
        while (host.got_q.size() < tx_q.size() && n < 300) begin
            @(posedge clock);
            n++;
        end
        repeat (2) @(posedge clock);
        #1;
        check(host.got_q.size() == tx_q.size(), "reply length");
        while (tx_q.size() > 0 && host.got_q.size() > 0)
            check(host.got_q.pop_front() === tx_q.pop_front(), "reply byte");
        check(msg_avail === 1'b0, "flag stuck");
        tx_q.delete();
        host.got_q.delete();
    endtask : respond

    // Executor side: random acceptance, compare each popped command
    always begin
        @(posedge clock);
        #1;
        cmd_ready = !hold && ($urandom % 4 != 0);
    end
    // Sampled mid-cycle: the pop happens at the next rising edge with these settled values
    always @(negedge clock) begin
        if (reset_n && cmd_valid && cmd_ready) begin
            check(exp_q.size() > 0, "extra command");
            exp_c = exp_q.pop_front();
            m = ~({256{1'b1}} << (8 * exp_c.len));
            check((cmd.text & m) === exp_c.text && cmd.len === exp_c.len, "command text");
            check(cmd.common === exp_c.common, "command kind");
            check(cmd.query === exp_c.query && cmd.port === exp_c.port, "query or port");
        end
    end

    // Main sequence; each reply is read before the next command
    initial begin
        void'($urandom(32'hc3a6c44c));
        {reset_n, resp_valid, resp_last, echo_enable, local_request, stall, hold} = '0;
        {resp_data, status_byte, poll_enable} = '0;
        cmd_ready = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        reset_n = 1'b1;
        send_str("*IDN?\n", rcf_pkg::RCF_PORT_GPIB, 1'b1);
        drain();
        check(remote_mode === 1'b1 && remote_port === rcf_pkg::RCF_PORT_GPIB, "not remote");
        respond("1.5E-3");
        send_str("VOLT;*RST\r\n;;\n", rcf_pkg::RCF_PORT_SERIAL, 1'b0);
        drain();
        echo_enable = 1'b1;
        send_str("RNG?\r", rcf_pkg::RCF_PORT_SERIAL, 1'b0);
        drain();
        respond("7");
        echo_enable = 1'b0;
        send_str("X?\n", rcf_pkg::RCF_PORT_SERIAL, 1'b0);
        drain();
        respond("42");
        send_str("ABC", rcf_pkg::RCF_PORT_GPIB, 1'b1);
        send_str("D?\r;E", rcf_pkg::RCF_PORT_GPIB, 1'b1);
        drain();
        hold = 1'b1;
        fork
            send_str("a;b;c;d;e;f;", rcf_pkg::RCF_PORT_SERIAL, 1'b0);
            begin
                repeat (30) @(posedge clock);
                #1;
                check(rx_ready === 1'b0, "buffer never full");
                hold = 1'b0;
            end
        join
        drain();
        s = "";
        repeat (40) s = {s, "Z"};
        foreach (s[i]) s[i] = 8'h41 + 8'($urandom % 26);
        send_str({s, "\n"}, rcf_pkg::RCF_PORT_SERIAL, 1'b0);
        drain();
        repeat (8) begin
            status_byte = 8'($urandom);
            poll_enable = 8'($urandom);
            // No reply is pending here, so the availability bit reads zero
            exp_sb = {status_byte[7:5], 1'b0, status_byte[3:0]};
            repeat (3) @(posedge clock);
            #1;
            check(status_out === exp_sb, "status byte");
            check(indiv_stat === |(exp_sb & poll_enable), "individual status");
        end
        local_request = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(remote_mode === 1'b0, "still remote");
        local_request = 1'b0;
        send_str("*CLS\r", rcf_pkg::RCF_PORT_SERIAL, 1'b0);
        drain();
        check(remote_mode === 1'b1 && remote_port === rcf_pkg::RCF_PORT_SERIAL, "port not kept");
        give_verdict();
    end
endmodule : tb_top
